//--- dv/biopm_board.sv
// Board model that resolves the levels seen on the eight pins.
`timescale 1ns/100ps
`default_nettype none
module biopm_board (
  input wire logic ref_clk, // Clock.
  input wire logic [7:0] pad_o_q, // Pad value.
  input wire logic [7:0] pad_oe_q, // Pad enable.
  input wire logic [7:0] pad_pu_q, // Pull-up.
  input wire logic [7:0] ext_en, // Board drives.
  input wire logic [7:0] ext_val, // Board value.
  output logic [7:0] pin_in // Pin level.
);
  logic [7:0] flt_q = 8'h00;
  // A floating pin toggles so that no stale level can be mistaken.
  always @(posedge ref_clk)
    flt_q <= ~flt_q;
  always_comb
    pin_in = (pad_oe_q & pad_o_q) | (~pad_oe_q & ext_en & ext_val)
      | (~pad_oe_q & ~ext_en & (pad_pu_q | flt_q));
endmodule
`default_nettype wire

//--- dv/biopm_sva.sv
// Port checker for the I/O port block, bound into its top.
`timescale 1ns/100ps
`default_nettype none
module biopm_sva #(
  parameter [7:0] INT_CAP = 8'h0f,
  parameter [7:0] PU_CAP = 8'h07
) (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pready_q, // Ready.
  input wire logic [7:0] pad_o_q, // Pad value.
  input wire logic [7:0] pad_oe_q, // Pad enable.
  input wire logic [7:0] pad_pu_q, // Pull-up.
  input wire logic [7:0] alt_claim, // Claim.
  input wire logic [7:0] alt_oe, // Drive.
  input wire logic [7:0] alt_out, // Value.
  input wire logic [7:0] alt_od, // Open drain.
  input wire logic [7:0] alt_in_q, // To peripheral.
  input wire logic cpu_irq_mask, // Mask.
  input wire logic lp_wait, // Wait.
  input wire logic lp_halt, // Halt.
  input wire logic ext_irq_q, // Request.
  input wire logic wake_q // Wake.
);
  logic [7:0] pp_q, od1_q, out_q, clm_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pad outputs lag the peripheral inputs by one edge, so keep a copy.
  always @(posedge ref_clk)
  begin
    pp_q <= alt_claim & alt_oe & ~alt_od;
    od1_q <= alt_claim & alt_oe & alt_od & alt_out;
    out_q <= alt_out;
    clm_q <= alt_claim;
  end
  apb_ready_a: assert property (
    psel && !penable |=> pready_q ##1 !pready_q)
    else $error("ready missing or held");
  alt_drive_a: assert property (
    (pad_oe_q & pp_q) == pp_q && ((pad_o_q ^ out_q) & pp_q) == 8'h00)
    else $error("peripheral push-pull not driven");
  alt_odrain_a: assert property (
    (pad_oe_q & od1_q) == 8'h00)
    else $error("open drain drives high");
  pu_drive_a: assert property (
    (pad_pu_q & pad_oe_q) == 8'h00)
    else $error("pull-up on a driven pin");
  no_pullup_a: assert property (
    (pad_pu_q & INT_CAP & ~PU_CAP) == 8'h00)
    else $error("pull-up on floating interrupt pin");
  irq_mask_a: assert property (
    ext_irq_q |-> !$past(cpu_irq_mask))
    else $error("request while masked");
  wake_lp_a: assert property (
    wake_q |-> $past(lp_wait) || $past(lp_halt))
    else $error("wake outside low power");
  latch_feed_a: assert property (
    ((pad_oe_q & ~clm_q) & (alt_in_q ^ pad_o_q)) == 8'h00)
    else $error("peripheral input differs from latch");
endmodule
bind biopm_top biopm_sva #(.INT_CAP(INT_CAP), .PU_CAP(PU_CAP)) u_sva (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pready_q(pready_q), .pad_o_q(pad_o_q), .pad_oe_q(pad_oe_q),
  .pad_pu_q(pad_pu_q), .alt_claim(alt_claim), .alt_oe(alt_oe),
  .alt_out(alt_out), .alt_od(alt_od), .alt_in_q(alt_in_q),
  .cpu_irq_mask(cpu_irq_mask), .lp_wait(lp_wait), .lp_halt(lp_halt),
  .ext_irq_q(ext_irq_q), .wake_q(wake_q));
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the I/O port block.
`timescale 1ns/100ps
`default_nettype none
`include "biopm_defs.vh"
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
  logic [7:0] paddr = 8'h00, alt_claim = 8'h00, alt_oe = 8'h00;
  logic [7:0] alt_out = 8'h00, alt_od = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic cpu_irq_mask = 1'b0, vector_fetch = 1'b0;
  logic lp_wait = 1'b0, lp_halt = 1'b0;
  wire logic [31:0] prdata_q;
  wire logic [7:0] pin_in, pad_o_q, pad_oe_q, pad_pu_q, alt_in_q;
  wire logic pready_q, pslverr_q, ext_irq_q, wake_q, irq_q;
  int mismatches = 0;
  int n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  biopm_top dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .pin_in(pin_in), .pad_o_q(pad_o_q), .pad_oe_q(pad_oe_q),
    .pad_pu_q(pad_pu_q), .alt_claim(alt_claim), .alt_oe(alt_oe),
    .alt_out(alt_out), .alt_od(alt_od), .alt_in_q(alt_in_q),
    .cpu_irq_mask(cpu_irq_mask), .vector_fetch(vector_fetch),
    .lp_wait(lp_wait), .lp_halt(lp_halt), .ext_irq_q(ext_irq_q),
    .wake_q(wake_q), .irq_q(irq_q));
  biopm_board u_board (.ref_clk(ref_clk), .pad_o_q(pad_o_q),
    .pad_oe_q(pad_oe_q), .pad_pu_q(pad_pu_q), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));
  task end_of_test;
    begin
      if (mismatches == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      n_compared++;
      if (g !== e)
      begin
        mismatches++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (pready_q !== 1'b1 && n < 16);
      rd = prdata_q;
      perr = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready_q !== 1'b1)
      begin
        mismatches++;
        end_of_test;
      end
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    begin
      apb(1'b0, `BIOPM_OFF_DIR, 8'h00);
      chk("dir reset", `BIOPM_RST_DIR, rd[7:0]);
      chk("mapped err", 8'h00, {7'h00, perr});
      apb(1'b0, `BIOPM_OFF_EN, 8'h00);
      chk("en reset", `BIOPM_RST_EN, rd[7:0]);
      apb(1'b0, 8'h40, 8'h00);
      chk("unmapped err", 8'h01, {7'h00, perr});
    end
  endtask
  task t_out;
    begin
      apb(1'b1, `BIOPM_OFF_DATA, 8'ha5);
      apb(1'b1, `BIOPM_OFF_OPT, 8'h0f);
      apb(1'b1, `BIOPM_OFF_DIR, 8'hff);
      repeat (2) @(posedge ref_clk);
      chk("out oe", 8'h5f, pad_oe_q);
      chk("out val", 8'h05, pad_o_q & pad_oe_q);
      apb(1'b0, `BIOPM_OFF_DATA, 8'h00);
      chk("latch read", 8'ha5, rd[7:0]);
    end
  endtask
  task t_in;
    begin
      ext_en <= 8'h0f;
      ext_val <= 8'h0c;
      apb(1'b1, `BIOPM_OFF_DIR, 8'h00);
      apb(1'b1, `BIOPM_OFF_OPT, 8'hff);
      apb(1'b1, `BIOPM_OFF_DATA, 8'h33);
      repeat (2) @(posedge ref_clk);
      chk("in oe", 8'h00, pad_oe_q);
      chk("pull-up", 8'hf7, pad_pu_q);
      apb(1'b0, `BIOPM_OFF_DATA, 8'h00);
      chk("pin read", 8'hfc, rd[7:0]);
      apb(1'b0, `BIOPM_OFF_ISEL, 8'h00);
      chk("irq sel", 8'h0f, rd[7:0]);
    end
  endtask
  task t_irq;
    begin
      ext_en <= 8'hff;
      ext_val <= 8'h00;
      apb(1'b1, `BIOPM_OFF_SENS, {6'h00, `BIOPM_SENS_RISE});
      apb(1'b1, `BIOPM_OFF_CLR, 8'hff);
      apb(1'b1, `BIOPM_OFF_EN, 8'hff);
      // Level events before the sensitivity change leave a request behind.
      vector_fetch <= 1'b1;
      @(posedge ref_clk);
      vector_fetch <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("irq idle", 8'h00, {7'h00, ext_irq_q});
      ext_val <= 8'h21;
      repeat (4) @(posedge ref_clk);
      chk("ext irq", 8'h01, {7'h00, ext_irq_q});
      apb(1'b0, `BIOPM_OFF_STAT, 8'h00);
      chk("status", 8'h01, rd[7:0]);
      chk("irq on", 8'h01, {7'h00, irq_q});
      cpu_irq_mask <= 1'b1;
      lp_halt <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("masked", 8'h00, {7'h00, ext_irq_q});
      chk("wake", 8'h01, {7'h00, wake_q});
      vector_fetch <= 1'b1;
      lp_halt <= 1'b0;
      @(posedge ref_clk);
      vector_fetch <= 1'b0;
      apb(1'b0, `BIOPM_OFF_REQ, 8'h00);
      chk("fetch clear", 8'h00, rd[7:0]);
      ext_val <= 8'h23;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, `BIOPM_OFF_REQ, 8'h00);
      chk("req again", 8'h01, rd[7:0]);
      lp_wait <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("wake wait", 8'h01, {7'h00, wake_q});
      lp_wait <= 1'b0;
      apb(1'b1, `BIOPM_OFF_SENS, {6'h00, `BIOPM_SENS_FALL});
      apb(1'b0, `BIOPM_OFF_REQ, 8'h00);
      chk("sens clear", 8'h00, rd[7:0]);
      apb(1'b1, `BIOPM_OFF_EN, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk("irq off", 8'h00, {7'h00, irq_q});
      cpu_irq_mask <= 1'b0;
    end
  endtask
  task t_alt;
    begin
      apb(1'b1, `BIOPM_OFF_OPT, 8'h00);
      apb(1'b1, `BIOPM_OFF_DIR, 8'h00);
      ext_en <= 8'hf0;
      ext_val <= 8'ha0;
      alt_claim <= 8'h0f;
      alt_oe <= 8'h0f;
      alt_out <= 8'h05;
      alt_od <= 8'h0c;
      repeat (2) @(posedge ref_clk);
      chk("alt oe", 8'h0b, pad_oe_q);
      chk("alt val", 8'h01, pad_o_q & pad_oe_q);
      apb(1'b0, `BIOPM_OFF_DATA, 8'h00);
      chk("alt read", 8'ha5, rd[7:0]);
      alt_claim <= 8'h1f;
      apb(1'b1, `BIOPM_OFF_DATA, 8'h10);
      apb(1'b1, `BIOPM_OFF_DIR, 8'h10);
      repeat (2) @(posedge ref_clk);
      chk("alt in", 8'h0b, {4'h0, alt_in_q[7:4]});
    end
  endtask
  // Clock enable low must freeze the pads although the claim drops.
  task t_ce;
    begin
      ce <= 1'b0;
      alt_claim <= 8'h00;
      repeat (3) @(posedge ref_clk);
      chk("ce hold", 8'h0b, pad_oe_q);
      ce <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("ce run", 8'h00, pad_oe_q);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_out;
    t_in;
    t_irq;
    t_alt;
    t_ce;
    end_of_test;
  end
  initial
  begin
    #200000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire

//--- inc/biopm_defs.vh
// Register offsets, reset values and encodings of the I/O port block.
`ifndef BIOPM_DEFS_VH
`define BIOPM_DEFS_VH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define BIOPM_OFF_DATA 8'h00
`define BIOPM_OFF_DIR 8'h04
`define BIOPM_OFF_OPT 8'h08
`define BIOPM_OFF_SENS 8'h0c
`define BIOPM_OFF_ISEL 8'h10
`define BIOPM_OFF_STAT 8'h14
`define BIOPM_OFF_CLR 8'h18
`define BIOPM_OFF_EN 8'h1c
`define BIOPM_OFF_REQ 8'h20

// ****************************************************************
// Reset values
// ****************************************************************
`define BIOPM_RST_DATA 8'h00
`define BIOPM_RST_DIR 8'h00
`define BIOPM_RST_OPT 8'h00
`define BIOPM_RST_SENS 2'h0
`define BIOPM_RST_EN 8'h00

// ****************************************************************
// Sensitivity codes and request register fields
// ****************************************************************
`define BIOPM_SENS_LOW 2'h0
`define BIOPM_SENS_RISE 2'h1
`define BIOPM_SENS_FALL 2'h2
`define BIOPM_SENS_BOTH 2'h3
`define BIOPM_REQ_PEND 0
`define BIOPM_REQ_WAKE 1

`endif

//--- rtl/biopm_det.v
// Event detector for the interrupt inputs of one port group.
`timescale 1ns/100ps
`default_nettype none
`include "biopm_defs.vh"

module biopm_det #(
  parameter WIDTH = 8
) (
  input wire ref_clk, // Clock.
  input wire rst, // Asynchronous reset, active high.
  input wire ce, // Clock enable.
  input wire [WIDTH-1:0] sel, // Pin is an interrupt input.
  input wire [WIDTH-1:0] lvl, // Pin level.
  input wire [1:0] sens, // Sensitivity code.
  output wire [WIDTH-1:0] ev // Per-pin event this cycle.
);

  reg [WIDTH-1:0] prev_q;
  reg [WIDTH-1:0] det;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prev_q <= {WIDTH{1'b1}};
    else if (ce)
      prev_q <= lvl;
  end

  always @*
  begin
    case (sens)
      `BIOPM_SENS_LOW: det = ~lvl;
      `BIOPM_SENS_RISE: det = lvl & ~prev_q;
      `BIOPM_SENS_FALL: det = ~lvl & prev_q;
      `BIOPM_SENS_BOTH: det = lvl ^ prev_q;
      default: det = {WIDTH{1'b0}};
    endcase
  end

  assign ev = det & sel;

endmodule
`default_nettype wire

//--- rtl/biopm_pin.v
// Mode logic of one port pin: pad drive, pull-up, read-back and routing.
`timescale 1ns/100ps
`default_nettype none

module biopm_pin #(
  parameter INT_CAP = 1'b0,
  parameter PU_CAP = 1'b1
) (
  input wire ref_clk, // Clock.
  input wire rst, // Asynchronous reset, active high.
  input wire ce, // Clock enable.
  input wire dir, // Direction bit, one is output.
  input wire opt, // Option bit.
  input wire latch, // Stored data latch bit.
  input wire pin_in, // Pin level.
  input wire alt_claim, // Peripheral owns the pin.
  input wire alt_oe, // Peripheral drives the pin.
  input wire alt_out, // Peripheral output value.
  input wire alt_od, // Peripheral wants open drain.
  output reg pad_o_q, // Pad output value.
  output reg pad_oe_q, // Pad output enable.
  output reg pad_pu_q, // Pad pull-up enable.
  output reg alt_in_q, // Level seen by the peripheral.
  output wire rd_bit, // Data register read-back.
  output wire irq_sel // Pin is an interrupt input.
);

  wire alt_drv;
  reg val;
  reg od;
  reg drv;

  assign alt_drv = alt_claim & alt_oe;

  always @*
  begin
    if (alt_drv)
    begin
      val = alt_out;
      od = alt_od;
      drv = 1'b1;
    end
    else if (dir)
    begin
      val = latch;
      od = ~opt;
      drv = 1'b1;
    end
    else
    begin
      val = 1'b0;
      od = 1'b0;
      drv = 1'b0;
    end
  end

  // Pull-up only on a plain input with option set; interrupt pins
  // built without a pull-up stay floating.
  assign irq_sel = INT_CAP & ~dir & opt;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pad_o_q <= 1'b0;
      pad_oe_q <= 1'b0;
      pad_pu_q <= 1'b0;
      alt_in_q <= 1'b0;
    end
    else if (ce)
    begin
      pad_o_q <= val & ~od;
      pad_oe_q <= drv & ~(od & val);
      pad_pu_q <= ~drv & opt & (~INT_CAP | PU_CAP);
      alt_in_q <= dir ? latch : pin_in;
    end
  end

  // Input with peripheral driving reads the peripheral; output reads latch.
  assign rd_bit = dir ? latch : (alt_drv ? alt_out : pin_in);

endmodule
`default_nettype wire

//--- rtl/biopm_top.v
// Top of the eight-pin I/O port: APB registers, pins and interrupts.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "biopm_defs.vh"

module biopm_top #(
  parameter [7:0] INT_CAP = 8'h0f,
  parameter [7:0] PU_CAP = 8'h07
) (
  input wire ref_clk, // Clock, 250 MHz.
  input wire rst, // Asynchronous reset, active high.
  input wire ce, // Clock enable; low freezes all state.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction, high is write.
  input wire [7:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata_q, // APB read data.
  output reg pready_q, // APB ready.
  output reg pslverr_q, // APB error on unmapped address.
  input wire [7:0] pin_in, // Pin levels.
  output wire [7:0] pad_o_q, // Pad output values.
  output wire [7:0] pad_oe_q, // Pad output enables.
  output wire [7:0] pad_pu_q, // Pad pull-up enables.
  input wire [7:0] alt_claim, // Peripheral owns pin.
  input wire [7:0] alt_oe, // Peripheral drives pin.
  input wire [7:0] alt_out, // Peripheral output values.
  input wire [7:0] alt_od, // Peripheral open-drain request.
  output wire [7:0] alt_in_q, // Levels to peripherals.
  input wire cpu_irq_mask, // Interrupt mask of cpu_condition_flags.
  input wire vector_fetch, // CPU fetches this group's vector.
  input wire lp_wait, // Device in wait mode.
  input wire lp_halt, // Device in halt mode.
  output reg ext_irq_q, // External interrupt request to CPU.
  output reg wake_q, // Wake-up request from wait or halt.
  output reg irq_q // Status interrupt, level.
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] port_data_latch_q;
  reg [7:0] dir_q;
  reg [7:0] opt_q;
  reg [1:0] ext_irq_sensitivity_ctrl_q;
  reg [7:0] stat_q;
  reg [7:0] en_q;
  reg req_q;

  wire [7:0] rd_vec;
  wire [7:0] isel;
  wire [7:0] ev;
  wire setup;
  wire acc;
  wire wr;
  reg [31:0] rdata;
  reg hit;

  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;

  // ****************************************************************
  // Pins
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : pins
      biopm_pin #(
        .INT_CAP(INT_CAP[g]),
        .PU_CAP(PU_CAP[g])
      ) u_pin (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .dir(dir_q[g]),
        .opt(opt_q[g]),
        .latch(port_data_latch_q[g]),
        .pin_in(pin_in[g]),
        .alt_claim(alt_claim[g]),
        .alt_oe(alt_oe[g]),
        .alt_out(alt_out[g]),
        .alt_od(alt_od[g]),
        .pad_o_q(pad_o_q[g]),
        .pad_oe_q(pad_oe_q[g]),
        .pad_pu_q(pad_pu_q[g]),
        .alt_in_q(alt_in_q[g]),
        .rd_bit(rd_vec[g]),
        .irq_sel(isel[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Interrupt detection
  // ****************************************************************
  biopm_det #(
    .WIDTH(8)
  ) u_det (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .sel(isel),
    .lvl(pin_in),
    .sens(ext_irq_sensitivity_ctrl_q),
    .ev(ev)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Low-power inputs only steer wake-up; nothing here resets on them,
  // so the pins keep their state through wait and halt.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port_data_latch_q <= `BIOPM_RST_DATA;
      dir_q <= `BIOPM_RST_DIR;
      opt_q <= `BIOPM_RST_OPT;
      ext_irq_sensitivity_ctrl_q <= `BIOPM_RST_SENS;
      en_q <= `BIOPM_RST_EN;
    end
    else if (ce && wr)
    begin
      case (paddr)
        `BIOPM_OFF_DATA: port_data_latch_q <= pwdata[7:0];
        `BIOPM_OFF_DIR: dir_q <= pwdata[7:0];
        `BIOPM_OFF_OPT: opt_q <= pwdata[7:0];
        `BIOPM_OFF_SENS: ext_irq_sensitivity_ctrl_q <= pwdata[1:0];
        `BIOPM_OFF_EN: en_q <= pwdata[7:0];
        default: en_q <= en_q;
      endcase
    end
  end

  // ****************************************************************
  // Request latch and status
  // ****************************************************************
  // A new event wins over a vector fetch or a sensitivity change in the
  // same cycle, so a late edge is never lost.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      req_q <= 1'b0;
      stat_q <= 8'h00;
    end
    else if (ce)
    begin
      if (|ev)
        req_q <= 1'b1;
      else if (vector_fetch || (wr && paddr == `BIOPM_OFF_SENS))
        req_q <= 1'b0;
      if (wr && paddr == `BIOPM_OFF_CLR)
        stat_q <= (stat_q & ~pwdata[7:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_irq_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_irq_q <= req_q & ~cpu_irq_mask;
      wake_q <= req_q & (lp_wait | lp_halt);
      irq_q <= |(stat_q & en_q);
    end
  end

  // ****************************************************************
  // APB read and answer
  // ****************************************************************
  always @*
  begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `BIOPM_OFF_DATA: rdata[7:0] = rd_vec;
      `BIOPM_OFF_DIR: rdata[7:0] = dir_q;
      `BIOPM_OFF_OPT: rdata[7:0] = opt_q;
      `BIOPM_OFF_SENS: rdata[1:0] = ext_irq_sensitivity_ctrl_q;
      `BIOPM_OFF_ISEL: rdata[7:0] = isel;
      `BIOPM_OFF_STAT: rdata[7:0] = stat_q;
      `BIOPM_OFF_CLR: rdata = 32'h0000_0000;
      `BIOPM_OFF_EN: rdata[7:0] = en_q;
      `BIOPM_OFF_REQ:
      begin
        rdata[`BIOPM_REQ_PEND] = req_q;
        rdata[`BIOPM_REQ_WAKE] = wake_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // Ready rises one cycle after setup; read data is sampled in setup,
  // so every access costs exactly one access cycle with no wait.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup && !pwrite)
        prdata_q <= rdata;
    end
  end

endmodule
`default_nettype wire
